// ===== crs_pkg.sv
// constants, types and field layout for the small execution core
// Function
// - return_with_literal loads immediate into accumulator
// - return loads pc from stack_top_entry, flags kept
// - return takes two cycles, fetched word dropped
// - sleep clears watchdog_counter and its prescaler
// - sleep sets expiry flag, clears power-down flag
// - sleep halts oscillator until wake-up
// - file address 0..31, destination bit picks target
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - subtract accumulator from file, update c dc z
// - nibble exchange swaps halves, flags kept
package crs_pkg;
	localparam int data_w = 8;
	localparam int pc_w = 9;
	localparam int instr_w = 12;
	localparam int addr_w = 5;
	localparam int file_depth = 32;
	localparam int apb_aw = 12;
	localparam int apb_dw = 32;

	// instruction word layout
	localparam int op_msb = 11;
	localparam int op_lsb = 9;
	localparam int k_msb = 7;
	localparam int k_lsb = 0;
	localparam int f_msb = 4;
	localparam int f_lsb = 0;
	localparam int dest_bit = 5;

	// opcodes
	localparam logic [2:0] op_nop = 3'h0;
	localparam logic [2:0] op_ret_lit = 3'h1;
	localparam logic [2:0] op_sleep = 3'h2;
	localparam logic [2:0] op_rot_left = 3'h3;
	localparam logic [2:0] op_rot_right = 3'h4;
	localparam logic [2:0] op_sub_acc = 3'h5;
	localparam logic [2:0] op_nib_swap = 3'h6;

	localparam logic dest_accum = 1'b0;
	localparam logic dest_file = 1'b1;

	// register offsets (byte addresses)
	localparam logic [11:0] off_ctrl = 12'h000;
	localparam logic [11:0] off_status = 12'h004;
	localparam logic [11:0] off_accum = 12'h008;
	localparam logic [11:0] off_pc = 12'h00c;

	// control and status bit positions
	localparam int ctrl_run_bit = 0;
	localparam int st_carry_bit = 0;
	localparam int st_dcarry_bit = 1;
	localparam int st_zero_bit = 2;
	localparam int st_pwrdn_bit = 3;
	localparam int st_to_bit = 4;
	localparam int st_pcw_bit = 5;
	localparam int st_sleep_bit = 6;

	// reset values
	localparam logic [8:0] pc_rst = 9'h000;
	localparam logic [7:0] accum_rst = 8'h00;
	localparam logic [7:0] file_rst = 8'h00;
	localparam logic [11:0] instr_rst = 12'h000;
	localparam logic run_rst = 1'b0;
	localparam logic to_rst = 1'b1;
	localparam logic pwrdn_rst = 1'b1;
	localparam logic flag_rst = 1'b0;

	typedef enum logic {crs_st_run, crs_st_sleep} crs_state_t;
endpackage

// ===== crs_alu_if.sv
// operand and result bundle between core and arithmetic unit
interface crs_alu_if;
	logic [2:0] op;
	logic [7:0] fval;
	logic [7:0] accum;
	logic cin;
	logic [7:0] result;
	logic cout;
	logic dcout;
	logic zout;
	modport core (output op, output fval, output accum, output cin,
		input result, input cout, input dcout, input zout);
	modport alu (input op, input fval, input accum, input cin,
		output result, output cout, output dcout, output zout);
endinterface

// ===== crs_alu.sv
// arithmetic unit for rotate, subtract and nibble exchange
module crs_alu (
	// operands and results
	crs_alu_if.alu a
);
	logic [8:0] diff;

	always_comb begin
		diff = {1'b0, a.fval} - {1'b0, a.accum};
		a.result = a.fval;
		a.cout = a.cin;
		a.dcout = 1'b0;
		a.zout = 1'b0;
		case (a.op)
			crs_pkg::op_rot_left: begin
				{a.cout, a.result} = {a.fval, a.cin};
			end
			crs_pkg::op_rot_right: begin
				{a.result, a.cout} = {a.cin, a.fval};
			end
			crs_pkg::op_sub_acc: begin
				// carry is the inverted borrow
				a.result = diff[7:0];
				a.cout = ~diff[8];
				a.dcout = (a.fval[3:0] >= a.accum[3:0]);
				a.zout = (diff[7:0] == 8'h00);
			end
			crs_pkg::op_nib_swap: begin
				a.result = {a.fval[3:0], a.fval[7:4]};
			end
			default: begin
				a.result = a.fval;
			end
		endcase
	end
endmodule

// ===== crs_file_mem.sv
// 32 x 8 file register store with registered read and write bypass
module crs_file_mem (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// read port
	input wire logic [4:0] rd_addr,
	output logic [7:0] rd_data,
	// write port
	input wire logic wr_en,
	input wire logic [4:0] wr_addr,
	input wire logic [7:0] wr_data
);
	logic [7:0] mem_reg [crs_pkg::file_depth];
	logic [7:0] mem_next [crs_pkg::file_depth];
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;

	genvar i;
	generate
		for (i = 0; i < crs_pkg::file_depth; i++) begin : g_entry
			localparam logic [4:0] idx = 5'(i);
			always_comb begin
				mem_next[i] = (wr_en && wr_addr == idx) ? wr_data : mem_reg[i];
			end
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_reg[i] <= crs_pkg::file_rst;
				end else if (clk_en) begin
					mem_reg[i] <= mem_next[i];
				end
			end
		end
	endgenerate

	// bypass so a result written now is seen by the very next instruction
	always_comb begin
		rd_data_next = (wr_en && wr_addr == rd_addr) ? wr_data : mem_reg[rd_addr];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data_reg <= crs_pkg::file_rst;
		end else if (clk_en) begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data = rd_data_reg;
endmodule

// ===== crs_core.sv
// execution core top with apb register access
//
// The register addresses and the APB register port are this design's own decisions.
module crs_core (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// program memory
	output logic [8:0] imem_addr,
	input wire logic [11:0] imem_data,
	// return stack
	input wire logic [8:0] stack_top_entry,
	output logic stack_pop,
	// watchdog and power-down
	output logic wdt_clear,
	output logic osc_halt,
	input wire logic wake_event,
	input wire logic pin_change_wake
);
	crs_pkg::crs_state_t state_reg, state_next;
	logic [8:0] pc_reg, pc_next;
	logic [11:0] instr_reg, instr_next;
	logic instr_valid_reg, instr_valid_next;
	logic [7:0] accum_reg, accum_next;
	logic carry_reg, carry_next;
	logic dcarry_reg, dcarry_next;
	logic zero_reg, zero_next;
	logic wdt_exp_reg, wdt_exp_next;
	logic pwrdn_reg, pwrdn_next;
	logic pcw_reg, pcw_next;
	logic run_reg, run_next;
	logic wdt_clear_reg, wdt_clear_next;
	logic stack_pop_reg, stack_pop_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic loaded_reg, loaded_next;

	logic advance;
	logic [2:0] exec_op;
	logic [7:0] k_val;
	logic dest_sel;
	logic [4:0] f_addr;
	logic reg_op;
	logic [4:0] rd_addr;
	logic [7:0] file_rd_data;
	logic file_wr_en;
	logic apb_wr;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic [7:0] status_byte;

	crs_alu_if alu_bus ();

	crs_alu u_alu (
		.a(alu_bus.alu)
	);

	crs_file_mem u_mem (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.rd_addr(rd_addr),
		.rd_data(file_rd_data),
		.wr_en(file_wr_en),
		.wr_addr(f_addr),
		.wr_data(alu_bus.result)
	);

	// decode of the instruction in execute
	assign advance = run_reg && (state_reg == crs_pkg::crs_st_run);
	assign exec_op = instr_valid_reg ? instr_reg[crs_pkg::op_msb:crs_pkg::op_lsb]
		: crs_pkg::op_nop;
	assign k_val = instr_reg[crs_pkg::k_msb:crs_pkg::k_lsb];
	assign dest_sel = instr_reg[crs_pkg::dest_bit];
	assign f_addr = instr_reg[crs_pkg::f_msb:crs_pkg::f_lsb];
	assign reg_op = (exec_op == crs_pkg::op_rot_left) || (exec_op == crs_pkg::op_rot_right)
		|| (exec_op == crs_pkg::op_sub_acc) || (exec_op == crs_pkg::op_nib_swap);
	// read the operand of the word being fetched so it is ready at execute
	assign rd_addr = advance ? imem_data[crs_pkg::f_msb:crs_pkg::f_lsb] : f_addr;
	assign file_wr_en = advance && reg_op && (dest_sel == crs_pkg::dest_file);

	assign alu_bus.op = exec_op;
	assign alu_bus.fval = file_rd_data;
	assign alu_bus.accum = accum_reg;
	assign alu_bus.cin = carry_reg;

	// apb handshake: read data is captured one enabled edge before ready
	assign pready = clk_en && loaded_reg;
	assign apb_wr = psel && penable && pwrite && loaded_reg;

	assign status_byte = {1'b0, (state_reg == crs_pkg::crs_st_sleep), pcw_reg,
		wdt_exp_reg, pwrdn_reg, zero_reg, dcarry_reg, carry_reg};

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (paddr)
			crs_pkg::off_ctrl: rd_mux[crs_pkg::ctrl_run_bit] = run_reg;
			crs_pkg::off_status: rd_mux[7:0] = status_byte;
			crs_pkg::off_accum: rd_mux[7:0] = accum_reg;
			crs_pkg::off_pc: rd_mux[8:0] = pc_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	always_comb begin
		loaded_next = loaded_reg;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (psel && !loaded_reg) begin
			loaded_next = 1'b1;
			prdata_next = rd_mux;
			pslverr_next = !rd_hit;
		end else if (psel && penable && loaded_reg) begin
			loaded_next = 1'b0;
		end else if (!psel) begin
			loaded_next = 1'b0;
		end
	end

	// execution, fetch and flag next state
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		instr_next = instr_reg;
		instr_valid_next = instr_valid_reg;
		accum_next = accum_reg;
		carry_next = carry_reg;
		dcarry_next = dcarry_reg;
		zero_next = zero_reg;
		wdt_exp_next = wdt_exp_reg;
		pwrdn_next = pwrdn_reg;
		pcw_next = pcw_reg;
		run_next = run_reg;
		wdt_clear_next = 1'b0;
		stack_pop_next = 1'b0;
		// software writes first, so execution results win a collision
		if (apb_wr && !pslverr_reg) begin
			case (paddr)
				crs_pkg::off_ctrl: run_next = pwdata[crs_pkg::ctrl_run_bit];
				crs_pkg::off_status: begin
					if (pwdata[crs_pkg::st_pcw_bit]) begin
						pcw_next = 1'b0;
					end
				end
				crs_pkg::off_accum: accum_next = pwdata[7:0];
				default: run_next = run_reg;
			endcase
		end
		if (pin_change_wake) begin
			pcw_next = 1'b1;
		end
		case (state_reg)
			crs_pkg::crs_st_run: begin
				if (advance) begin
					pc_next = pc_reg + 9'h001;
					instr_next = imem_data;
					instr_valid_next = 1'b1;
					case (exec_op)
						crs_pkg::op_ret_lit: begin
							accum_next = k_val;
							pc_next = stack_top_entry;
							stack_pop_next = 1'b1;
							instr_valid_next = 1'b0;
						end
						crs_pkg::op_sleep: begin
							wdt_clear_next = 1'b1;
							wdt_exp_next = 1'b1;
							pwrdn_next = 1'b0;
							state_next = crs_pkg::crs_st_sleep;
						end
						crs_pkg::op_rot_left, crs_pkg::op_rot_right: begin
							carry_next = alu_bus.cout;
						end
						crs_pkg::op_sub_acc: begin
							carry_next = alu_bus.cout;
							dcarry_next = alu_bus.dcout;
							zero_next = alu_bus.zout;
						end
						default: begin
							carry_next = carry_reg;
						end
					endcase
					if (reg_op && dest_sel == crs_pkg::dest_accum) begin
						accum_next = alu_bus.result;
					end
				end
			end
			crs_pkg::crs_st_sleep: begin
				// nothing fetched or executed until wake-up
				if (wake_event) begin
					state_next = crs_pkg::crs_st_run;
				end
			end
			default: state_next = crs_pkg::crs_st_run;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= crs_pkg::crs_st_run;
			pc_reg <= crs_pkg::pc_rst;
			instr_reg <= crs_pkg::instr_rst;
			instr_valid_reg <= 1'b0;
			accum_reg <= crs_pkg::accum_rst;
			carry_reg <= crs_pkg::flag_rst;
			dcarry_reg <= crs_pkg::flag_rst;
			zero_reg <= crs_pkg::flag_rst;
			wdt_exp_reg <= crs_pkg::to_rst;
			pwrdn_reg <= crs_pkg::pwrdn_rst;
			pcw_reg <= crs_pkg::flag_rst;
			run_reg <= crs_pkg::run_rst;
			wdt_clear_reg <= 1'b0;
			stack_pop_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			loaded_reg <= 1'b0;
		end else if (clk_en) begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			instr_reg <= instr_next;
			instr_valid_reg <= instr_valid_next;
			accum_reg <= accum_next;
			carry_reg <= carry_next;
			dcarry_reg <= dcarry_next;
			zero_reg <= zero_next;
			wdt_exp_reg <= wdt_exp_next;
			pwrdn_reg <= pwrdn_next;
			pcw_reg <= pcw_next;
			run_reg <= run_next;
			wdt_clear_reg <= wdt_clear_next;
			stack_pop_reg <= stack_pop_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			loaded_reg <= loaded_next;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign imem_addr = pc_reg;
	assign stack_pop = stack_pop_reg;
	assign wdt_clear = wdt_clear_reg;
	assign osc_halt = (state_reg == crs_pkg::crs_st_sleep);

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_return_accum_load: assert property (
		clk_en && advance && exec_op == crs_pkg::op_ret_lit |=> accum_reg == $past(k_val)
	) else $error("return did not load the literal");

	chk_return_pc_load: assert property (
		clk_en && advance && exec_op == crs_pkg::op_ret_lit
		|=> pc_reg == $past(stack_top_entry) && stack_pop
			&& $stable(carry_reg) && $stable(dcarry_reg) && $stable(zero_reg)
	) else $error("return pc or flags wrong");

	chk_return_two_cycle: assert property (
		clk_en && advance && exec_op == crs_pkg::op_ret_lit |=> !instr_valid_reg
	) else $error("fetched word after return not dropped");

	chk_sleep_wdt_clear: assert property (
		clk_en && advance && exec_op == crs_pkg::op_sleep |=> wdt_clear ##1 !wdt_clear
	) else $error("watchdog clear pulse missing");

	chk_sleep_flag_set: assert property (
		clk_en && advance && exec_op == crs_pkg::op_sleep
		|=> wdt_exp_reg && !pwrdn_reg && ($past(pcw_reg) -> pcw_reg)
	) else $error("sleep flags wrong");

	// software may still write the accumulator while the core sleeps
	chk_sleep_halt_hold: assert property (
		osc_halt && !wake_event && !apb_wr
		|=> osc_halt && $stable(pc_reg) && $stable(accum_reg)
	) else $error("core moved while asleep");

	chk_dest_select: assert property (
		clk_en && advance && reg_op && !apb_wr
		|=> accum_reg == (($past(dest_sel) == crs_pkg::dest_file) ? $past(accum_reg)
			: $past(alu_bus.result))
	) else $error("destination select wrong");

	chk_rotate_left_carry: assert property (
		clk_en && advance && exec_op == crs_pkg::op_rot_left
		|=> carry_reg == $past(file_rd_data[7]) && $stable(zero_reg)
	) else $error("left rotate carry wrong");

	chk_rotate_right_carry: assert property (
		clk_en && advance && exec_op == crs_pkg::op_rot_right
		|=> carry_reg == $past(file_rd_data[0]) && $stable(dcarry_reg)
	) else $error("right rotate carry wrong");

	chk_sub_flag_update: assert property (
		clk_en && advance && exec_op == crs_pkg::op_sub_acc
		|=> carry_reg == ($past(file_rd_data) >= $past(accum_reg))
			&& zero_reg == ($past(file_rd_data) == $past(accum_reg))
	) else $error("subtract flags wrong");

	chk_swap_accum_result: assert property (
		clk_en && advance && exec_op == crs_pkg::op_nib_swap
		&& dest_sel == crs_pkg::dest_accum
		|=> accum_reg == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}
			&& $stable(carry_reg)
	) else $error("nibble exchange wrong");

	chk_rotate_left_bit0: assert property (
		advance && exec_op == crs_pkg::op_rot_left |-> alu_bus.result[0] == carry_reg
	) else $error("old carry not in bit 0");
endmodule

// ===== crs_imem_model.sv
// program memory model answering fetches in the same cycle
module crs_imem_model (
	// fetch port
	input wire logic [8:0] imem_addr,
	output logic [11:0] imem_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [11:0] mem [0:511];
	// combinational read: the core expects the word in its fetch cycle
	assign imem_data = mem[imem_addr];
endmodule

// ===== crs_core_tb_top.sv
// self-checking bench for the execution core
module crs_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [7:0] a;
		logic [7:0] b;
		logic [2:0] op;
		logic d;
		logic [4:0] fa;
	} crs_row_t;
	logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic stack_pop, wdt_clear, osc_halt, wake_event, pin_change_wake, err;
	logic [11:0] paddr, imem_data;
	logic [31:0] pwdata, prdata, rd;
	logic [8:0] imem_addr, stack_top_entry;
	logic [15:0] e;
	int failures = 0;
	int checks_done = 0;
	int cycles = 0;
	int pops = 0;
	int clears = 0;
	// a: accum before run, file = 0 - a; b: literal loaded by the return
	crs_row_t rows [8] = '{
		'{8'h01, 8'h5a, crs_pkg::op_rot_left, 1'b0, 5'h00},
		'{8'h80, 8'h00, crs_pkg::op_rot_right, 1'b1, 5'h1f},
		'{8'h00, 8'h00, crs_pkg::op_sub_acc, 1'b0, 5'h11},
		'{8'h10, 8'h01, crs_pkg::op_sub_acc, 1'b1, 5'h07},
		'{8'h0f, 8'hff, crs_pkg::op_sub_acc, 1'b0, 5'h1f},
		'{8'h3c, 8'h99, crs_pkg::op_nib_swap, 1'b1, 5'h02},
		'{8'hc1, 8'h00, crs_pkg::op_rot_right, 1'b0, 5'h00},
		'{8'h02, 8'hff, crs_pkg::op_nib_swap, 1'b0, 5'h1e}};

	crs_core dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .imem_addr(imem_addr), .imem_data(imem_data),
		.stack_top_entry(stack_top_entry), .stack_pop(stack_pop), .wdt_clear(wdt_clear),
		.osc_halt(osc_halt), .wake_event(wake_event), .pin_change_wake(pin_change_wake));
	crs_imem_model pm_u (.imem_addr(imem_addr), .imem_data(imem_data));

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		cycles++;
		if (stack_pop === 1'b1) pops++;
		if (wdt_clear === 1'b1) clears++;
		if (cycles == 5000) begin
			failures++;
			end_of_test;
		end
	end

	task automatic end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset;
		presetn <= 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		pops = 0;
		clears = 0;
		for (int i = 0; i < 512; i++) pm_u.mem[i] = 12'h000;
	endtask

	// setup, then access held until pready is seen high at an edge
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(a, 1'b0, 32'h0000_0000);
		cmp(rd, exp);
	endtask

	task automatic wait_halt;
		int n;
		n = 0;
		while (osc_halt !== 1'b1 && n < 200) begin
			@(posedge pclk);
			n++;
		end
		cmp({31'h0, osc_halt}, 32'h0000_0001);
	endtask

	function automatic logic [11:0] w(input logic [2:0] op, input logic d, input logic [4:0] f);
		return {op, 3'h0, d, f};
	endfunction

	// returns {status, accum} after op, optional swap readback, then sleep
	function automatic logic [15:0] exp_row(input crs_row_t r);
		logic [7:0] f, res, acc;
		logic c, dc, z;
		f = 8'h00 - r.a;
		z = (f == 8'h00);
		dc = (r.a[3:0] == 4'h0);
		c = f[7];
		acc = r.b;
		res = f;
		case (r.op)
			crs_pkg::op_rot_left: begin
				res = {f[6:0], c};
				c = f[7];
			end
			crs_pkg::op_rot_right: begin
				res = {c, f[7:1]};
				c = f[0];
			end
			crs_pkg::op_sub_acc: begin
				res = f - acc;
				c = (f >= acc);
				dc = (f[3:0] >= acc[3:0]);
				z = (res == 8'h00);
			end
			default: res = {f[3:0], f[7:4]};
		endcase
		acc = r.d ? {res[3:0], res[7:4]} : res;
		return {8'h50 | {5'h00, z, dc, c}, acc};
	endfunction

	initial begin
		{presetn, clk_en, psel, penable, pwrite, wake_event, pin_change_wake} = 7'h00;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		stack_top_entry = 9'h010;
		clk_en = 1'b1;
		do_reset;
		rdc(crs_pkg::off_ctrl, 32'h0000_0000);
		rdc(crs_pkg::off_status, 32'h0000_0018);
		rdc(crs_pkg::off_accum, 32'h0000_0000);
		rdc(crs_pkg::off_pc, 32'h0000_0000);
		apb(12'h010, 1'b0, 32'h0000_0000);
		cmp({31'h0, err}, 32'h0000_0001);
		cmp(rd, 32'h0000_0000);
		$display("test reset_values done");
		foreach (rows[i]) begin
			do_reset;
			pm_u.mem[0] = w(crs_pkg::op_sub_acc, 1'b1, rows[i].fa);
			pm_u.mem[1] = w(crs_pkg::op_rot_left, 1'b0, rows[i].fa);
			pm_u.mem[2] = {crs_pkg::op_ret_lit, 1'b0, rows[i].b};
			// fetched behind the return; running it would corrupt the file
			pm_u.mem[3] = w(crs_pkg::op_sub_acc, 1'b1, rows[i].fa);
			pm_u.mem[16] = w(rows[i].op, rows[i].d, rows[i].fa);
			pm_u.mem[17] = rows[i].d ? w(crs_pkg::op_nib_swap, 1'b0, rows[i].fa) : 12'h000;
			pm_u.mem[18] = w(crs_pkg::op_sleep, 1'b0, 5'h00);
			apb(crs_pkg::off_accum, 1'b1, {24'h0, rows[i].a});
			apb(crs_pkg::off_ctrl, 1'b1, 32'h0000_0001);
			wait_halt;
			e = exp_row(rows[i]);
			rdc(crs_pkg::off_accum, {24'h0, e[7:0]});
			rdc(crs_pkg::off_status, {24'h0, e[15:8]});
			cmp(32'(pops), 32'h0000_0001);
			cmp(32'(clears), 32'h0000_0001);
			$display("test row %0d done", i);
		end
		do_reset;
		pm_u.mem[0] = w(crs_pkg::op_sleep, 1'b0, 5'h00);
		pm_u.mem[1] = {crs_pkg::op_ret_lit, 1'b0, 8'hff};
		pm_u.mem[2] = {crs_pkg::op_ret_lit, 1'b0, 8'hff};
		pm_u.mem[16] = w(crs_pkg::op_sleep, 1'b0, 5'h00);
		pin_change_wake <= 1'b1;
		@(posedge pclk);
		pin_change_wake <= 1'b0;
		apb(crs_pkg::off_ctrl, 1'b1, 32'h0000_0001);
		wait_halt;
		repeat (20) @(posedge pclk);
		rdc(crs_pkg::off_accum, 32'h0000_0000);
		rdc(crs_pkg::off_status, 32'h0000_0070);
		cmp(32'(clears), 32'h0000_0001);
		wake_event <= 1'b1;
		@(posedge pclk);
		wake_event <= 1'b0;
		repeat (3) @(posedge pclk);
		wait_halt;
		rdc(crs_pkg::off_accum, 32'h0000_00ff);
		cmp(32'(pops), 32'h0000_0001);
		apb(crs_pkg::off_status, 1'b1, 32'h0000_0020);
		rdc(crs_pkg::off_status, 32'h0000_0050);
		rdc(crs_pkg::off_pc, 32'h0000_0012);
		$display("test sleep_wake done");
		// a wake request seen only while frozen is lost, not queued
		clk_en <= 1'b0;
		wake_event <= 1'b1;
		repeat (3) @(posedge pclk);
		wake_event <= 1'b0;
		clk_en <= 1'b1;
		rdc(crs_pkg::off_status, 32'h0000_0050);
		$display("test clock_enable done");
		end_of_test;
	end
endmodule
